// >>> hw/dual_adc_convert_read_sequencer.sv
// host-side sequencer that starts conversions and reads both results
//
// Overview of operation
// - select changes after start high, 500 ns setup
// - never change select during conversion
// - one chip select pulse, two read strobes
// - 400 ns quiet after read before start
// - cycle is conversion, read, quiet: 5.7 us
`timescale 1ns/1ps
`default_nettype none
module dual_adc_convert_read_sequencer (
    input  wire logic        clk_i,                  // 200 MHz clock
    input  wire logic        rst_i,                  // sync reset, active high
    input  wire logic        convert_req_i,          // request one conversion
    input  wire logic        pair_sel_i,             // pair wanted: 0 = A, 1 = B
    input  wire logic        bipolar_i,              // 1 = two's complement part
    output logic             convert_ready_o,        // idle, request taken
    output logic             conversion_start_n_o,   // start pin, active low
    output logic             input_pair_select_o,    // pair select pin
    input  wire logic        busy_i,                 // device busy pin
    output logic             chip_select_n_o,        // chip select pin
    output logic             read_n_o,               // read strobe pin
    input  wire logic [13:0] data_i,                 // device data bus
    output logic      [15:0] result_o,               // {pair, index, code}
    output logic             result_valid_o,         // result available
    input  wire logic        result_ready_i,         // consumer accepts
    output logic      [15:0] result_signed_o,        // code sign-extended when bipolar_i, else zero-extended
    output logic             timeout_o               // busy overran, pulse
);
    // ********************************************************************
    // sequencer
    // ********************************************************************
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_SETUP = 8'h02,
        ST_START = 8'h04,
        ST_CONV  = 8'h08,
        ST_CS    = 8'h10,
        ST_RDLO  = 8'h20,
        ST_RDHI  = 8'h40,
        ST_QUIET = 8'h80
    } seq_e;

    localparam logic [10:0] CONV_MAX  = 11'(adc_host_pkg::CONV_CYC + 16);
    localparam logic [10:0] SETUP_MAX = 11'(adc_host_pkg::SETUP_CYC - 1);
    localparam logic [10:0] START_MAX = 11'(adc_host_pkg::START_CYC - 1);
    localparam logic [10:0] STRB_MAX  = 11'(adc_host_pkg::STROBE_CYC - 1);
    localparam logic [10:0] QUIET_MAX = 11'(adc_host_pkg::QUIET_CYC - 1);

    seq_e        st_q;
    logic [10:0] tmr_q;
    logic        idx_q;
    logic        sel_q;
    logic        in_ready;
    logic        push;
    logic        tmo_q;
    logic        first_q;

    assign convert_ready_o = (st_q == ST_IDLE);
    assign push            = (st_q == ST_RDLO) && (tmr_q == STRB_MAX) && in_ready;

    // state and timer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= ST_IDLE;
            tmr_q   <= 11'h000;
            idx_q   <= 1'b0;
            tmo_q   <= 1'b0;
            first_q <= 1'b1;
        end else begin
            tmo_q <= 1'b0;
            unique case (st_q)
                ST_IDLE: begin
                    tmr_q <= 11'h000;
                    if (convert_req_i) begin
                        // a changed select needs its settle time first
                        st_q <= (pair_sel_i != sel_q || first_q) ? ST_SETUP : ST_START;
                    end
                end
                ST_SETUP: begin
                    tmr_q <= tmr_q + 11'h001;
                    if (tmr_q == SETUP_MAX) begin
                        tmr_q <= 11'h000;
                        st_q  <= ST_START;
                    end
                end
                ST_START: begin
                    first_q <= 1'b0;
                    tmr_q   <= tmr_q + 11'h001;
                    if (tmr_q == START_MAX) begin
                        tmr_q <= 11'h000;
                        st_q  <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // wait for busy to drop; a dead device is timed out
                    tmr_q <= tmr_q + 11'h001;
                    if (tmr_q > 11'h002 && !busy_i) begin
                        tmr_q <= 11'h000;
                        idx_q <= 1'b0;
                        st_q  <= ST_CS;
                    end else if (tmr_q == CONV_MAX) begin
                        tmr_q <= 11'h000;
                        idx_q <= 1'b0;
                        tmo_q <= 1'b1;
                        st_q  <= ST_CS;
                    end
                end
                ST_CS: begin
                    st_q <= ST_RDLO;
                end
                ST_RDLO: begin
                    // strobe stays low while the buffer is full
                    if (tmr_q != STRB_MAX) begin
                        tmr_q <= tmr_q + 11'h001;
                    end else if (in_ready) begin
                        tmr_q <= 11'h000;
                        st_q  <= ST_RDHI;
                    end
                end
                ST_RDHI: begin
                    tmr_q <= tmr_q + 11'h001;
                    if (tmr_q == STRB_MAX) begin
                        tmr_q <= 11'h000;
                        idx_q <= ~idx_q;
                        st_q  <= idx_q ? ST_QUIET : ST_RDLO;
                    end
                end
                ST_QUIET: begin
                    tmr_q <= tmr_q + 11'h001;
                    if (tmr_q == QUIET_MAX) begin
                        tmr_q <= 11'h000;
                        st_q  <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // select pin: only changes in idle, after start is back high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_q <= 1'b0;
        end else if (st_q == ST_IDLE && convert_req_i) begin
            sel_q <= pair_sel_i;
        end
    end

    // ********************************************************************
    // pins
    // ********************************************************************
    // pin registers, glitch free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_start_n_o <= 1'b1;
            chip_select_n_o      <= 1'b1;
            read_n_o             <= 1'b1;
        end else begin
            conversion_start_n_o <= !((st_q == ST_START && tmr_q != START_MAX)
                                      || (st_q == ST_SETUP && tmr_q == SETUP_MAX)
                                      || (st_q == ST_IDLE && convert_req_i
                                          && pair_sel_i == sel_q && !first_q));
            chip_select_n_o      <= !((st_q == ST_CONV && (tmr_q > 11'h002 && !busy_i
                                       || tmr_q == CONV_MAX)) || st_q == ST_CS
                                      || st_q == ST_RDLO
                                      || (st_q == ST_RDHI && !(idx_q && tmr_q == STRB_MAX)));
            read_n_o             <= !(st_q == ST_CS || (st_q == ST_RDLO && !push)
                                      || (st_q == ST_RDHI && !idx_q && tmr_q == STRB_MAX));
        end
    end
    assign input_pair_select_o = sel_q;

    // ********************************************************************
    // result path
    // ********************************************************************
    // tag: pair (from sel_q) and read index, then code
    result_buffer #(
        .WIDTH(16)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   ({sel_q, idx_q, data_i}),
        .in_valid_i  ((st_q == ST_RDLO) && (tmr_q == STRB_MAX)),
        .in_ready_o  (in_ready),
        .out_data_o  (result_o),
        .out_valid_o (result_valid_o),
        .out_ready_i (result_ready_i)
    );

    // two's complement sign extension or zero extension
    assign result_signed_o = bipolar_i ? {{2{result_o[13]}}, result_o[13:0]}
                                       : {2'b00, result_o[13:0]};
    assign timeout_o = tmo_q;

    // ********************************************************************
    // checks
    // ********************************************************************
    chk_start_read_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(chip_select_n_o) |-> conversion_start_n_o [*8])
        else $error("start too soon after read");
    chk_select_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        !conversion_start_n_o || st_q == ST_CONV |-> $stable(input_pair_select_o))
        else $error("select moved during conversion");
    chk_read_inside_cs: assert property (@(posedge clk_i) disable iff (rst_i)
        !read_n_o |-> !chip_select_n_o)
        else $error("read strobe outside chip select");
    chk_no_read_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(chip_select_n_o) |-> $past(st_q) == ST_CONV)
        else $error("read began outside end of conversion");
    chk_sign_extend: assert property (@(posedge clk_i) disable iff (rst_i)
        bipolar_i && result_o[13:0] == adc_host_pkg::BIP_MAX |-> result_signed_o == 16'h1FFF)
        else $error("bad positive extension");
    chk_neg_extend: assert property (@(posedge clk_i) disable iff (rst_i)
        bipolar_i && result_o[13:0] == adc_host_pkg::BIP_MIN |-> result_signed_o == 16'hE000)
        else $error("bad negative extension");
    chk_minus_one: assert property (@(posedge clk_i) disable iff (rst_i)
        bipolar_i && result_o[13:0] == adc_host_pkg::BIP_NEG1 |-> result_signed_o == 16'hFFFF)
        else $error("bad minus one");
    chk_order_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(chip_select_n_o) |=> !idx_q)
        else $error("read order not restarted");
endmodule
`default_nettype wire

// >>> hw/adc_host_pkg.sv
// constants for the dual converter host sequencer
package adc_host_pkg;
    localparam int unsigned CLK_PERIOD_PS    = 5000;           // 200 MHz
    localparam int unsigned CONV_TIME_NS     = 5200;           // conversion time
    localparam int unsigned PAIR_SETUP_NS    = 500;            // select settle before start
    localparam int unsigned QUIET_NS         = 400;            // read end to next start
    localparam int unsigned READ_TIME_NS     = 100;            // whole read operation
    localparam int unsigned CYCLE_TIME_NS    = 5700;           // fastest throughput
    localparam int unsigned START_LOW_NS     = 50;             // start pulse width
    localparam int unsigned CONV_CYC   = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETUP_CYC  = (PAIR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned QUIET_CYC  = (QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned START_CYC  = (START_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STROBE_CYC = (READ_TIME_NS * 1000) / (4 * CLK_PERIOD_PS);
    localparam int unsigned DATA_W     = 14;                   // result width
    localparam int unsigned CNT_W      = 11;                   // timer width
    localparam logic [13:0] BIP_MAX    = 14'h1FFF;             // most positive two's complement
    localparam logic [13:0] BIP_MIN    = 14'h2000;             // most negative two's complement
    localparam logic [13:0] BIP_NEG1   = 14'h3FFF;             // just below ground
endpackage

// >>> hw/result_buffer.sv
// two-entry valid/ready buffer for converter results
`timescale 1ns/1ps
`default_nettype none
module result_buffer #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clk_i,      // clock
    input  wire logic             rst_i,      // sync reset
    input  wire logic [WIDTH-1:0] in_data_i,  // incoming word
    input  wire logic             in_valid_i, // incoming valid
    output logic                  in_ready_o, // space available
    output logic      [WIDTH-1:0] out_data_o, // head word
    output logic                  out_valid_o,// head valid
    input  wire logic             out_ready_i // drain accepts
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wr_q;
    logic             rd_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    // handshakes
    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage and pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// >>> test/adc_device_model.sv
// behavioural model of the dual converter as the host sees it
`timescale 1ns/1ps
`default_nettype none
module adc_device_model (
    input  wire logic             clk_i,     // stands in for the internal oscillator
    input  wire logic             start_n_i, // conversion start, active low
    input  wire logic             sel_i,     // pair select
    input  wire logic             cs_n_i,    // chip select, active low
    input  wire logic             rd_n_i,    // read strobe, active low
    input  wire logic             slow_i,    // stretch the conversion
    input  wire logic             hang_i,    // never end the conversion
    input  wire logic [3:0][13:0] codes_i,   // codes by {pair, index}
    output logic                  busy_o,    // busy pin
    output logic      [13:0]      data_o     // data bus
);
    // ******
    // conversion and read pointer
    // ******
    logic        start_q = 1'b1;
    logic        rd_q    = 1'b1;
    logic        pair_q  = 1'b0;
    logic        ptr_q   = 1'b0;
    logic        busy_q  = 1'b0;
    logic [13:0] last_q  = 14'h0000;
    int          cnt_q   = 0;
    // start edge holds both channels, busy ends after the conversion time
    always @(posedge clk_i) begin
        start_q <= start_n_i;
        rd_q    <= rd_n_i;
        if (start_q && !start_n_i) begin
            busy_q <= 1'b1;
            pair_q <= sel_i;
            ptr_q  <= 1'b0;
            cnt_q  <= adc_host_pkg::CONV_CYC + (slow_i ? 8 : 0);
        end else if (busy_q && !hang_i) begin
            cnt_q <= cnt_q - 1;
            if (cnt_q <= 1) busy_q <= 1'b0;
        end
        if (!rd_q && rd_n_i && !cs_n_i) ptr_q <= 1'b1;
        if (!cs_n_i && !rd_n_i) last_q <= data_o;
    end
    // bus driven only inside a strobe; released it shows the last word read, inverted
    assign busy_o = busy_q;
    assign data_o = (!cs_n_i && !rd_n_i) ? codes_i[{pair_q, ptr_q}] : ~last_q;
endmodule
`default_nettype wire

// >>> test/tb_dual_adc_convert_read_sequencer.sv
// self-checking bench for the dual converter host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_dual_adc_convert_read_sequencer;
    // ******
    // signals and instances
    // ******
    localparam int CYC = adc_host_pkg::CYCLE_TIME_NS * 1000 / adc_host_pkg::CLK_PERIOD_PS;
    logic clk_i = 1'b0, rst_i = 1'b1, convert_req_i = 1'b0, pair_sel_i = 1'b0, bipolar_i = 1'b1;
    logic result_ready_i = 1'b0, slow_i = 1'b0, hang_i = 1'b0, mon_on = 1'b1;
    logic convert_ready_o, start_n, sel, busy, cs_n, rd_n, result_valid_o, timeout_o;
    logic cs_q = 1'b1, st_q = 1'b1, sel_q = 1'b0, rd_q = 1'b1;
    logic [13:0] data;
    logic [15:0] result_o, result_signed_o;
    logic [3:0][13:0] codes;
    int n_fail = 0, check_count = 0, cyc = 0, t_cs = 9999, t_sel = 9999, t_st = 9999, n_rd = 0;
    // codes by {pair, index}: bipolar extremes on pair A, minus one and ground on pair B
    assign codes = {14'h0000, adc_host_pkg::BIP_NEG1, adc_host_pkg::BIP_MIN, adc_host_pkg::BIP_MAX};
    // clock at 200 MHz
    always #2.5 clk_i = ~clk_i;
    dual_adc_convert_read_sequencer u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .convert_req_i(convert_req_i), .pair_sel_i(pair_sel_i), .bipolar_i(bipolar_i),
        .convert_ready_o(convert_ready_o), .conversion_start_n_o(start_n),
        .input_pair_select_o(sel), .busy_i(busy), .chip_select_n_o(cs_n), .read_n_o(rd_n),
        .data_i(data), .result_o(result_o), .result_valid_o(result_valid_o),
        .result_ready_i(result_ready_i), .result_signed_o(result_signed_o),
        .timeout_o(timeout_o));
    adc_device_model u_dev (.clk_i(clk_i), .start_n_i(start_n), .sel_i(sel), .cs_n_i(cs_n),
        .rd_n_i(rd_n), .slow_i(slow_i), .hang_i(hang_i), .codes_i(codes), .busy_o(busy),
        .data_o(data));
    // ******
    // shared tasks
    // ******
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("fails=%0d checks=%0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic request(input logic p);
        int n = 0;
        while (convert_ready_o !== 1'b1 && n < 3000) begin tick(1); n++; end
        if (n >= 3000) n_fail++;
        pair_sel_i = p;
        convert_req_i = 1'b1;
        tick(1);
        convert_req_i = 1'b0;
    endtask
    task automatic pop(output logic [15:0] w, output logic [15:0] s, output int n);
        n = 0;
        while (result_valid_o !== 1'b1 && n < 3000) begin tick(1); n++; end
        if (n >= 3000) n_fail++;
        w = result_o;
        s = result_signed_o;
        result_ready_i = 1'b1;
        tick(1);
        result_ready_i = 1'b0;
    endtask
    function automatic logic [15:0] ext(input logic [13:0] c, input logic b);
        return b ? {{2{c[13]}}, c} : {2'b00, c};
    endfunction
    // ******
    // scenarios
    // ******
    // one conversion on pair p, both words in order with their extension
    task automatic run_pair(input logic p, input logic b);
        logic [15:0] w, s;
        int n;
        bipolar_i = b;
        request(p);
        pop(w, s, n);
        check(16'(n >= adc_host_pkg::CONV_CYC), 16'h0001);
        check(w, {p, 1'b0, codes[{p, 1'b0}]});
        check(s, ext(codes[{p, 1'b0}], b));
        pop(w, s, n);
        check(w, {p, 1'b1, codes[{p, 1'b1}]});
        check(s, ext(codes[{p, 1'b1}], b));
    endtask
    // receiver stalls: the buffer fills and the next strobe is held low
    task automatic stall();
        logic [15:0] w, s;
        int n = 0;
        bipolar_i = 1'b1;
        request(1'b0);
        request(1'b1);
        while (rd_n !== 1'b0 && n < 3000) begin tick(1); n++; end
        tick(20);
        check({15'h0000, rd_n}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            pop(w, s, n);
            check(w, {i[1], i[0], codes[i[1:0]]});
            // let an edge pass so ready is not lowered and raised in one step
            tick(1);
        end
        tick(2);
        check({15'h0000, result_valid_o}, 16'h0000);
    endtask
    // device never ends its conversion: one timeout pulse, then reset
    task automatic hang();
        int n = 0;
        hang_i = 1'b1;
        request(1'b0);
        mon_on = 1'b0;
        while (timeout_o !== 1'b1 && n < 1400) begin tick(1); n++; end
        check({15'h0000, timeout_o}, 16'h0001);
        tick(1);
        check({15'h0000, timeout_o}, 16'h0000);
        hang_i = 1'b0;
        rst_i = 1'b1;
        tick(10);
        rst_i = 1'b0;
        tick(1);
        check({15'h0000, convert_ready_o}, 16'h0001);
    endtask
    // pin watcher: start spacing, select changes, read framing, hang limit
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 20000) begin n_fail++; test_done(); end
        if (!rst_i && mon_on) begin
            t_cs++;
            t_sel++;
            t_st++;
            if (st_q && !start_n) begin
                check(16'(t_cs >= adc_host_pkg::QUIET_CYC), 16'h0001);
                check(16'(t_sel >= adc_host_pkg::SETUP_CYC), 16'h0001);
                check(16'(t_st >= CYC), 16'h0001);
                t_st = 0;
            end
            if (sel != sel_q) begin
                check({15'h0000, start_n & ~busy}, 16'h0001);
                t_sel = 0;
            end
            if (!cs_n) check({15'h0000, busy}, 16'h0000);
            if (!rd_n) check({15'h0000, cs_n}, 16'h0000);
            if (rd_q && !rd_n) n_rd++;
            if (!cs_q && cs_n) begin
                check(16'(n_rd), 16'h0002);
                n_rd = 0;
                t_cs = 0;
            end
        end
        cs_q <= cs_n;
        st_q <= start_n;
        sel_q <= sel;
        rd_q <= rd_n;
    end
    // main sequence
    initial begin
        tick(10);
        rst_i = 1'b0;
        run_pair(1'b0, 1'b1);
        run_pair(1'b1, 1'b1);
        run_pair(1'b1, 1'b0);
        slow_i = 1'b1;
        run_pair(1'b0, 1'b1);
        slow_i = 1'b0;
        stall();
        hang();
        test_done();
    end
endmodule
`default_nettype wire
